//--- sbsf_pkg.sv
// sbsf_pkg: shared constants of the serial port buffer status block
// assumes: nothing beyond a SystemVerilog compiler
package sbsf_pkg;
  localparam int DATA_W = 8;
  localparam int DEPTH = 4;
  // register byte addresses
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  // status fields
  localparam int STAT_RBF_BIT = 0;
  localparam int STAT_TBF_BIT = 1;
  localparam int STAT_TXCNT_LSB = 8;
  localparam int STAT_RXCNT_LSB = 12;
  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ENH_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0;
endpackage

//--- sbsf_sync.sv
// sbsf_sync: two-flop level synchroniser
// assumes: d is a level from another clock domain
`timescale 1ns/1ps
`default_nettype none
module sbsf_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

//--- sbsf_link.sv
// sbsf_link: shift register on the serial clock, word handshakes by toggle
// assumes: slave mode, sample on rising edge of link clock, msb first
`timescale 1ns/1ps
`default_nettype none
module sbsf_link
#(
  parameter int W = 8
)
(
  input wire logic sck,
  input wire logic rst_n,
  input wire logic ss_n,
  input wire logic sdi,
  output logic sdo,
  input wire logic [W-1:0] tx_word,
  input wire logic tx_tgl,
  output logic tx_ack_tgl,
  output logic [W-1:0] rx_word,
  output logic rx_tgl
);
  logic [W-1:0] shreg;
  logic [$clog2(W+1)-1:0] bitcnt;
  logic tx_s1, tx_s2;
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shreg <= '0;
      bitcnt <= '0;
      tx_ack_tgl <= 1'b0;
      rx_word <= '0;
      rx_tgl <= 1'b0;
      tx_s1 <= 1'b0;
      tx_s2 <= 1'b0;
    end
    else
    begin
      tx_s1 <= tx_tgl;
      tx_s2 <= tx_s1;
      if (!ss_n)
      begin
        if (bitcnt == '0 && tx_s2 != tx_ack_tgl)
        begin
          // load holding word into shift register
          shreg <= {tx_word[W-2:0], sdi};
          tx_ack_tgl <= tx_s2;
        end
        else
          shreg <= {shreg[W-2:0], sdi};
        if (bitcnt == ($clog2(W+1))'(W-1))
        begin
          bitcnt <= '0;
          rx_word <= (bitcnt == '0) ? {tx_word[W-2:0], sdi}
                                    : {shreg[W-2:0], sdi};
          rx_tgl <= ~rx_tgl;
        end
        else
          bitcnt <= bitcnt + 1'b1;
      end
    end
  end
  assign sdo = (bitcnt == '0) ? tx_word[W-1] : shreg[W-1];
endmodule
`default_nettype wire

//--- sbsf_top.sv
// sbsf_top: buffer full flags of a serial port, wishbone register slave
// assumes: classic wishbone on CLOCK, serial link on its own clock SCK
// Contract
// [R1] transmit-full sits in status bit 1, set while transmit space is taken.
// [R2] standard mode: a write of the data window sets transmit-full.
// [R3] standard mode: moving the holding word to the shifter clears it.
// [R4] enhanced mode: transmit-full sets when a write takes the last entry.
// [R5] enhanced mode: transmit-full clears once any entry is free.
// [R6] receive-full sits in status bit 0, set while a received word waits.
// [R7] standard mode: a word moved in from the shifter sets receive-full.
// [R8] standard mode: a read of the data window clears receive-full.
// [R9] enhanced mode: receive-full sets when a word fills the last entry.
// [R10] enhanced mode: receive-full clears once any entry is free.
// [R11] software maps the port pins before use once enabled.
// [R12] entry count is a parameter; pointers and a count drive the flags.
`timescale 1ns/1ps
`default_nettype none
module sbsf_top
#(
  parameter int DEPTH = sbsf_pkg::DEPTH
)
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SCK,
  input wire logic SS_N,
  input wire logic SDI,
  output logic SDO,
  output logic TX_BUFFER_FULL_FLAG,
  output logic RX_BUFFER_FULL_FLAG
);
  localparam int W = sbsf_pkg::DATA_W;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // storage
  logic [W-1:0] tx_mem [DEPTH];
  logic [W-1:0] rx_mem [DEPTH];
  logic [PW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [PW-1:0] next_tx_wp, next_tx_rp, next_rx_wp, next_rx_rp;
  logic [CW-1:0] tx_cnt, rx_cnt, next_tx_cnt, next_rx_cnt;
  logic [1:0] ctrl, next_ctrl;
  logic ack, next_ack;
  logic [31:0] dat, next_dat;
  logic [W-1:0] tx_word, next_tx_word;
  logic tx_tgl, next_tx_tgl;
  logic tx_ack_seen, next_tx_ack_seen;
  logic rx_seen, next_rx_seen;
  logic [W-1:0] rx_hold, next_rx_hold;

  // link side
  logic tx_ack_tgl_l, rx_tgl_l, tx_ack_s, rx_tgl_s;
  logic [W-1:0] rx_word_l;
  logic sdo_l;

  sbsf_link #(.W(W)) u_link
  (
    .sck(SCK),
    .rst_n(RESETN),
    .ss_n(SS_N),
    .sdi(SDI),
    .sdo(sdo_l),
    .tx_word(tx_word),
    .tx_tgl(tx_tgl),
    .tx_ack_tgl(tx_ack_tgl_l),
    .rx_word(rx_word_l),
    .rx_tgl(rx_tgl_l)
  );

  sbsf_sync u_sync_txack
  (
    .clk(CLOCK),
    .rst_n(RESETN),
    .d(tx_ack_tgl_l),
    .q(tx_ack_s)
  );

  sbsf_sync u_sync_rx
  (
    .clk(CLOCK),
    .rst_n(RESETN),
    .d(rx_tgl_l),
    .q(rx_tgl_s)
  );

  logic enh, en, hit, wr_data, rd_data, wr_ctrl;
  logic in_flight, shifted, rx_arrive, tx_push, tx_pop, rx_push, rx_pop;
  logic tx_full_now, rx_full_now;

  always_comb
  begin
    en = ctrl[sbsf_pkg::CTRL_EN_BIT];
    enh = ctrl[sbsf_pkg::CTRL_ENH_BIT];
    hit = WB_CYC_I && WB_STB_I && !ack;
    wr_data = hit && WB_WE_I && WB_ADR_I == sbsf_pkg::ADDR_DATA && WB_SEL_I[0];
    rd_data = hit && !WB_WE_I && WB_ADR_I == sbsf_pkg::ADDR_DATA;
    wr_ctrl = hit && WB_WE_I && WB_ADR_I == sbsf_pkg::ADDR_CTRL && WB_SEL_I[0];
    in_flight = tx_tgl != tx_ack_seen;
    shifted = tx_ack_s != tx_ack_seen;
    rx_arrive = rx_tgl_s != rx_seen;
    // standard mode uses one entry; enhanced uses them all
    tx_full_now = enh ? (tx_cnt == CW'(DEPTH)) : (tx_cnt != '0); // [R12]
    rx_full_now = enh ? (rx_cnt == CW'(DEPTH)) : (rx_cnt != '0); // [R12]
    tx_push = wr_data && en && !tx_full_now;
    tx_pop = en && !in_flight && tx_cnt != '0;
    rx_push = rx_arrive && !rx_full_now;
    rx_pop = rd_data && rx_cnt != '0;
    next_tx_wp = tx_push ? PW'((tx_wp + 1'b1) % DEPTH) : tx_wp;
    next_tx_rp = tx_pop ? PW'((tx_rp + 1'b1) % DEPTH) : tx_rp;
    next_rx_wp = rx_push ? PW'((rx_wp + 1'b1) % DEPTH) : rx_wp;
    next_rx_rp = rx_pop ? PW'((rx_rp + 1'b1) % DEPTH) : rx_rp;
    // word staged for the link still takes its entry until shifted
    next_tx_cnt = tx_cnt + CW'(tx_push) - CW'(shifted); // [R2] [R4] [R3] [R5]
    next_rx_cnt = rx_cnt + CW'(rx_push) - CW'(rx_pop); // [R7] [R8]
    next_tx_word = tx_pop ? tx_mem[tx_rp] : tx_word;
    next_tx_tgl = tx_pop ? ~tx_tgl : tx_tgl;
    // moving the word to the shifter frees the entry
    next_tx_ack_seen = shifted ? tx_ack_s : tx_ack_seen; // [R3] [R5]
    next_rx_seen = rx_arrive ? rx_tgl_s : rx_seen;
    next_rx_hold = rx_pop ? rx_mem[rx_rp] : rx_hold;
    next_ctrl = wr_ctrl ? WB_DAT_I[1:0] : ctrl;
    if (!en)
    begin
      next_tx_wp = '0;
      next_tx_rp = '0;
      next_rx_wp = '0;
      next_rx_rp = '0;
      next_tx_cnt = '0;
      next_rx_cnt = '0;
    end
    next_ack = hit;
    next_dat = sbsf_pkg::UNMAPPED_READ;
    if (hit && !WB_WE_I)
    begin
      case (WB_ADR_I)
        sbsf_pkg::ADDR_DATA:
          next_dat = {{(32-W){1'b0}}, (rx_cnt != '0) ? rx_mem[rx_rp] : rx_hold};
        sbsf_pkg::ADDR_STAT:
        begin
          next_dat[sbsf_pkg::STAT_TBF_BIT] = tx_full_now; // [R1]
          next_dat[sbsf_pkg::STAT_RBF_BIT] = rx_full_now; // [R6]
          next_dat[sbsf_pkg::STAT_TXCNT_LSB +: 4] = 4'(tx_cnt);
          next_dat[sbsf_pkg::STAT_RXCNT_LSB +: 4] = 4'(rx_cnt);
        end
        sbsf_pkg::ADDR_CTRL:
          next_dat = {30'h0, ctrl};
        default:
          next_dat = sbsf_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tx_wp <= '0;
      tx_rp <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
      tx_cnt <= '0;
      rx_cnt <= '0;
      ctrl <= sbsf_pkg::CTRL_RESET;
      ack <= 1'b0;
      dat <= '0;
      tx_word <= '0;
      tx_tgl <= 1'b0;
      tx_ack_seen <= 1'b0;
      rx_seen <= 1'b0;
      rx_hold <= '0;
    end
    else
    begin
      tx_wp <= next_tx_wp;
      tx_rp <= next_tx_rp;
      rx_wp <= next_rx_wp;
      rx_rp <= next_rx_rp;
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
      ctrl <= next_ctrl;
      ack <= next_ack;
      dat <= next_dat;
      tx_word <= next_tx_word;
      tx_tgl <= next_tx_tgl;
      tx_ack_seen <= next_tx_ack_seen;
      rx_seen <= next_rx_seen;
      rx_hold <= next_rx_hold;
    end
  end

  // entry storage, no reset needed
  always_ff @(posedge CLOCK)
  begin
    if (tx_push)
      tx_mem[tx_wp] <= WB_DAT_I[W-1:0];
    if (rx_push)
      rx_mem[rx_wp] <= rx_word_l;
  end

  // flag outputs from flops; full flags follow the counts
  logic tx_flag, rx_flag;
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tx_flag <= 1'b0;
      rx_flag <= 1'b0;
    end
    else
    begin
      tx_flag <= enh ? (next_tx_cnt == CW'(DEPTH)) : (next_tx_cnt != '0); // [R4] [R5]
      rx_flag <= enh ? (next_rx_cnt == CW'(DEPTH)) : (next_rx_cnt != '0); // [R9] [R10]
    end
  end

  always_comb
  begin
    WB_DAT_O = dat;
    WB_ACK_O = ack;
    TX_BUFFER_FULL_FLAG = tx_flag;
    RX_BUFFER_FULL_FLAG = rx_flag;
    SDO = sdo_l;
  end
endmodule
`default_nettype wire

//--- sbsf_top_props.sv
// sbsf_top_props: port checks of sbsf_top
// assumes: bound into sbsf_top, system clock domain only
`timescale 1ns/1ps
`default_nettype none
module sbsf_top_props
#(
  parameter int DEPTH = 4
)
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  input wire logic SS_N,
  input wire logic TX_BUFFER_FULL_FLAG,
  input wire logic RX_BUFFER_FULL_FLAG
);
  logic [1:0] mode;
  logic rd_d;
  logic wr_d;
  assign rd_d = WB_ACK_O && !WB_WE_I && WB_ADR_I == sbsf_pkg::ADDR_DATA;
  assign wr_d = WB_ACK_O && WB_WE_I && WB_ADR_I == sbsf_pkg::ADDR_DATA;
  // enable and mode as software last wrote them
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
      mode <= 2'h0;
    else if (WB_ACK_O && WB_WE_I && WB_ADR_I == sbsf_pkg::ADDR_CTRL)
      mode <= WB_DAT_I[1:0];
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not acked");
  a_no_stray_ack: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("stray ack");
  a_tx_set_std: assert property (wr_d && mode == 2'h1 |-> ##[0:1] TX_BUFFER_FULL_FLAG)
    else $error("tx full not set");
  a_tx_rise_why: assert property ($rose(TX_BUFFER_FULL_FLAG) |-> wr_d || $past(wr_d))
    else $error("tx full rose alone");
  a_tx_fall_why: assert property ($fell(TX_BUFFER_FULL_FLAG) |-> !SS_N || WB_ACK_O || $past(WB_ACK_O))
    else $error("tx full fell alone");
  a_rx_clear_std: assert property (rd_d && mode == 2'h1 |-> ##[0:1] !RX_BUFFER_FULL_FLAG)
    else $error("rx full not cleared");
  a_rx_fall_why: assert property ($fell(RX_BUFFER_FULL_FLAG) |-> WB_ACK_O || $past(WB_ACK_O))
    else $error("rx full fell alone");
  c_tx_full: cover property ($rose(TX_BUFFER_FULL_FLAG));
  c_rx_full: cover property ($rose(RX_BUFFER_FULL_FLAG));
  c_enh_read: cover property (rd_d && mode == 2'h3);
endmodule
bind sbsf_top sbsf_top_props #(.DEPTH(DEPTH)) u_props (.CLOCK(CLOCK),
  .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
  .WB_ACK_O(WB_ACK_O), .SS_N(SS_N),
  .TX_BUFFER_FULL_FLAG(TX_BUFFER_FULL_FLAG),
  .RX_BUFFER_FULL_FLAG(RX_BUFFER_FULL_FLAG));
`default_nettype wire

//--- sbsf_peer.sv
// sbsf_peer: serial master at the far side of the link
// assumes: slave samples on rising sck, msb first
`timescale 1ns/1ps
`default_nettype none
module sbsf_peer
(
  output logic sck,
  output logic ss_n,
  output logic sdi,
  input wire logic sdo
);
  // one link clock pulse while reset is held
  initial
  begin
    sck = 1'h0;
    ss_n = 1'h1;
    sdi = 1'h0;
    #10 sck = 1'h1;
    #40 sck = 1'h0;
  end
  // after the reset pulse, clock runs only within a frame
  task automatic frame(input logic [7:0] d, output logic [7:0] q);
    // two deselected pulses let the slave see a waiting word
    repeat (2)
    begin
      #40 sck = 1'h1;
      #40 sck = 1'h0;
    end
    ss_n = 1'h0;
    for (int i = 7; i >= 0; i--)
    begin
      sdi = d[i];
      #40 q[i] = sdo;
      sck = 1'h1;
      #40 sck = 1'h0;
    end
    #40 ss_n = 1'h1;
    sdi = ~sdi;
  endtask
endmodule
`default_nettype wire

//--- tb_sbsf_top.sv
// tb_sbsf_top: self-checking bench of sbsf_top
// assumes: sbsf_peer drives the link, props bound in
`timescale 1ns/1ps
`default_nettype none
module tb_sbsf_top;
  localparam int D = 3;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  wire logic [31:0] dout;
  wire logic ack, txf, rxf, sck, ss_n, sdi, sdo;
  int fails = 0;
  int checks = 0;
  int seed = 32'h9e6c0321;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [7:0] bq[$];
  logic [7:0] sq[$];
  always #2.5 clk = ~clk;
  sbsf_top #(.DEPTH(D)) u_dut (.CLOCK(clk), .RESETN(rstn), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1),
    .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack), .SCK(sck),
    .SS_N(ss_n), .SDI(sdi), .SDO(sdo), .TX_BUFFER_FULL_FLAG(txf),
    .RX_BUFFER_FULL_FLAG(rxf));
  sbsf_peer u_peer (.sck(sck), .ss_n(ss_n), .sdi(sdi), .sdo(sdo));
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'h1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    fails += (n == 20);
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
    eq.push_back(e);
    mq.push_back(m);
    bus(1'h0, a, 32'h0);
  endtask
  task automatic wd();
    logic [7:0] v;
    v = 8'($random(seed));
    bq.push_back(v);
    bus(1'h1, sbsf_pkg::ADDR_DATA, {24'h0, v});
  endtask
  task automatic fr(input logic [7:0] e);
    logic [7:0] s;
    logic [7:0] q;
    s = 8'($random(seed));
    sq.push_back(s);
    #1.3;
    u_peer.frame(s, q);
    cmp(q, e);
    repeat (8) @(posedge clk);
  endtask
  always @(posedge clk)
    if (ack === 1'h1 && we === 1'h0 && eq.size() > 0)
      cmp(dout & mq.pop_front(), eq.pop_front());
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rd(sbsf_pkg::ADDR_STAT, 32'h0, 32'hffff);
    rd(4'hc, sbsf_pkg::UNMAPPED_READ, 32'hffffffff);
    $display("test reset done");
    bus(1'h1, sbsf_pkg::ADDR_CTRL, 32'h1);
    wd();
    cmp(txf, 1'h1);
    bus(1'h1, sbsf_pkg::ADDR_DATA, 32'ha5);
    fr(bq.pop_front());
    cmp({txf, rxf}, 2'h1);
    rd(sbsf_pkg::ADDR_STAT, 32'h1, 32'h3);
    rd(sbsf_pkg::ADDR_DATA, sq.pop_front(), 32'hff);
    cmp(rxf, 1'h0);
    $display("test standard done");
    bus(1'h1, sbsf_pkg::ADDR_CTRL, 32'h3);
    for (int k = 0; k < D; k++)
    begin
      wd();
      cmp(txf, k == D - 1);
    end
    for (int k = 0; k < D; k++)
    begin
      fr(bq.pop_front());
      cmp({txf, rxf}, {1'h0, k == D - 1});
    end
    for (int k = 0; k < D; k++)
    begin
      rd(sbsf_pkg::ADDR_DATA, sq.pop_front(), 32'hff);
      cmp(rxf, 1'h0);
    end
    $display("test enhanced done");
    final_report();
  end
  initial
  begin
    #50000;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
